// ---- common/aimx_defines.svh ----
/*
  Offsets, field positions, reset values and channel codes of the
  positive-input selector and the factory offset register.
  Assumes a byte-wide register word on a 32-bit Avalon-MM data bus.
*/
`ifndef AIMX_DEFINES_SVH
`define AIMX_DEFINES_SVH

`define AIMX_OFS_SELECT 8'hbb
`define AIMX_OFS_FACTORY_TEMP_OFFSET_HIGH 8'h86
`define AIMX_OFS_SENSOR_CTRL 8'hd0
`define AIMX_SELECT_RESET 5'h1f
`define AIMX_SELECT_MSB 4
`define AIMX_SENSOR_EN_BIT 2
`define AIMX_CODE_P0_LAST 5'h07
`define AIMX_CODE_P1_FIRST 5'h08
`define AIMX_CODE_P1_LAST 5'h0e
`define AIMX_CODE_TEMP 5'h1b
`define AIMX_CODE_VBAT 5'h1c
`define AIMX_CODE_VREG 5'h1d
`define AIMX_CODE_VDD 5'h1e
`define AIMX_CODE_GND 5'h1f

`endif

// ---- common/aimx_pkg.sv ----
/*
  Types of the analog input selector.
  Assumes aimx_defines.svh supplies the numbers.
*/
package aimx_pkg;

  typedef enum logic [2:0] {
    AIMX_SRC_PORT0 = 3'h0,
    AIMX_SRC_PORT1 = 3'h1,
    AIMX_SRC_TEMP = 3'h2,
    AIMX_SRC_VBAT = 3'h3,
    AIMX_SRC_VREG = 3'h4,
    AIMX_SRC_VDD = 3'h5,
    AIMX_SRC_GND = 3'h6,
    AIMX_SRC_NONE = 3'h7
  } aimx_src_t;

  typedef struct packed {
    aimx_src_t source;
    logic [7:0] port0_sel;
    logic [6:0] port1_sel;
    logic temp_sensor_enable;
    logic temp_sensor_hiz;
  } aimx_route_t;

endpackage

// ---- rtl/aimx_input_select.sv ----
/*
  Register control of the converter's positive-input selector and the
  read-only factory temperature-sensor offset high byte.
  Assumes an Avalon-MM master on clk_i and a factory offset value held
  in nonvolatile storage outside, presented steadily on factory_temp_offset_nv_i.
*/
// The implementer's own choice: the Avalon-MM slave port.
// What this block does
// - decode 5-bit code to port 0/1 pins, sensor, battery, core, main supply, ground
// - temperature sensor reaches converter only when selector picks its code
// - sensor output high impedance while its enable bit is clear
// - factory 10-bit offset bits 9:2 readable in all eight offset-register bits
// - offset survives reset; it is reloaded from stored value, not a constant
`timescale 1ns/1ps
`include "aimx_defines.svh"

module aimx_input_select (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic [9:0] factory_temp_offset_nv_i,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output aimx_pkg::aimx_route_t route_o
);

  logic [4:0] positive_input_code;
  logic temp_sensor_enable;
  logic [9:0] factory_temp_offset;
  logic [7:0] next_rdata;
  aimx_pkg::aimx_route_t next_route;

  // one wait cycle per access: the answer comes at the second edge
  // kept as a flop so the bus sees no combinational path from the request
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en_i) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      positive_input_code <= `AIMX_SELECT_RESET;
      temp_sensor_enable <= 1'b0;
    end else if (clk_en_i && avs_write && !avs_waitrequest && avs_byteenable[0]) begin
      if (avs_address == `AIMX_OFS_SELECT) begin
        positive_input_code <= avs_writedata[`AIMX_SELECT_MSB:0];
      end
      if (avs_address == `AIMX_OFS_SENSOR_CTRL) begin
        temp_sensor_enable <= avs_writedata[`AIMX_SENSOR_EN_BIT];
      end
    end
  end

  // reloaded from storage each cycle that clk_en_i is high, so reset never leaves a fixed value
  always_ff @(posedge clk_i) begin
    if (clk_en_i) begin
      factory_temp_offset <= factory_temp_offset_nv_i;
    end
  end

  always_comb begin
    case (avs_address)
      `AIMX_OFS_SELECT: next_rdata = {3'h0, positive_input_code};
      `AIMX_OFS_FACTORY_TEMP_OFFSET_HIGH: next_rdata = factory_temp_offset[9:2];
      `AIMX_OFS_SENSOR_CTRL: next_rdata = {5'h00, temp_sensor_enable, 2'h0};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en_i) begin
      avs_readdata <= {24'h00_0000, next_rdata};
    end
  end

  always_comb begin
    next_route = '0;
    next_route.temp_sensor_enable = temp_sensor_enable;
    next_route.temp_sensor_hiz = !temp_sensor_enable;
    if (positive_input_code <= `AIMX_CODE_P0_LAST) begin
      next_route.source = aimx_pkg::AIMX_SRC_PORT0;
      next_route.port0_sel = 8'h01 << positive_input_code[2:0];
    end else if (positive_input_code <= `AIMX_CODE_P1_LAST) begin
      next_route.source = aimx_pkg::AIMX_SRC_PORT1;
      next_route.port1_sel = 7'h01 << positive_input_code[2:0];
    end else begin
      case (positive_input_code)
        `AIMX_CODE_TEMP: next_route.source = aimx_pkg::AIMX_SRC_TEMP;
        `AIMX_CODE_VBAT: next_route.source = aimx_pkg::AIMX_SRC_VBAT;
        `AIMX_CODE_VREG: next_route.source = aimx_pkg::AIMX_SRC_VREG;
        `AIMX_CODE_VDD: next_route.source = aimx_pkg::AIMX_SRC_VDD;
        `AIMX_CODE_GND: next_route.source = aimx_pkg::AIMX_SRC_GND;
        default: next_route.source = aimx_pkg::AIMX_SRC_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      route_o <= '0;
      route_o.source <= aimx_pkg::AIMX_SRC_GND;
      route_o.temp_sensor_hiz <= 1'b1;
    end else if (clk_en_i) begin
      route_o <= next_route;
    end
  end

endmodule

// ---- tb/aimx_input_select_sva.sv ----
/* port checker of the input selector
   assumes a bind onto aimx_input_select */
`timescale 1ns/1ps
module aimx_input_select_sva (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [9:0] factory_temp_offset_nv_i,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire aimx_pkg::aimx_route_t route_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_FACTORY_TEMP_OFFSET: assert property (!avs_waitrequest && avs_read && avs_address == 8'h86
    |-> avs_readdata == {24'h0, factory_temp_offset_nv_i[9:2]}) else $error("offset read");
  AST_SEL_TOP: assert property (!avs_waitrequest && avs_read && avs_address == 8'hbb
    |-> avs_readdata[31:5] == 27'h0) else $error("select top bits");
  AST_TEMP: assert property (!avs_waitrequest && avs_write && avs_byteenable[0] && avs_address == 8'hbb
    && avs_writedata[4:0] == 5'h1b |-> ##[1:2] route_o.source == 3'h2) else $error("sensor route");
  AST_PORT0: assert property (route_o.source == 3'h0
    |-> $onehot(route_o.port0_sel) && route_o.port1_sel == 7'h0) else $error("port 0 pick");
  AST_INNER: assert property (route_o.source > 3'h1
    |-> route_o.port0_sel == 8'h0 && route_o.port1_sel == 7'h0) else $error("pin picked");
  AST_HIZ: assert property (route_o.temp_sensor_hiz == !route_o.temp_sensor_enable) else $error("sensor hiz");
endmodule
bind aimx_input_select aimx_input_select_sva u_sva (.*);

// ---- tb/test_aimx_input_select.sv ----
/* self-checking bench of the input selector
   assumes the design answers after one wait cycle */
`timescale 1ns/1ps
module test_aimx_input_select;
  logic clk_i = 0, rst_b_i = 0, clk_en_i = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [9:0] factory_temp_offset_nv_i = 10'h2b5;
  logic [7:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'h1;
  logic [4:0] c;
  aimx_pkg::aimx_route_t route_o;
  int mismatches = 0, num_checks = 0, cyc = 0;
  // write code, expected source
  logic [10:0] rows [11] = '{11'h000, 11'h038, 11'h041, 11'h071, 11'h07f, 11'h0d7, 11'h0da, 11'h0e3,
    11'h0ec, 11'h0f5, 11'h7fe};
  aimx_input_select dut (.*);
  always #12.5 clk_i = !clk_i;
  task automatic results;
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  // hold request until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    // two idle edges so registered route outputs have settled before any check
    @(posedge clk_i);
    @(posedge clk_i);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1;
    bus(0, 8'hbb, 0); chk("sel_rst", 32'h1f, q);
    foreach (rows[i]) begin
      bus(1, 8'hbb, rows[i][10:3]);
      bus(0, 8'hbb, 0); chk("sel", {27'h0, rows[i][7:3]}, q);
      c = rows[i][7:3];
      chk("route", {rows[i][2:0], c < 8 ? 8'h1 << c : 8'h0, c inside {[8:14]} ? 7'h1 << (c - 5'h8) : 7'h0},
        {14'h0, route_o[19:2]});
    end
    bus(1, 8'hd0, 8'h04); chk("sens_on", 32'h2, {30'h0, route_o[1:0]});
    bus(1, 8'hbb, 8'h1b); chk("cal_src", 32'h2, {29'h0, route_o.source});
    bus(1, 8'hd0, 8'h00); chk("sens_off", 32'h1, {30'h0, route_o[1:0]});
    bus(1, 8'h86, 8'hff);
    bus(0, 8'h86, 0); chk("factory_temp_offset", 32'had, q);
    bus(0, 8'h40, 0); chk("unmapped", 32'h0, q);
    // second reset with another stored value: offset must follow storage
    factory_temp_offset_nv_i <= 10'h14a;
    rst_b_i <= 0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1;
    bus(0, 8'h86, 0); chk("factory_temp_offset_rst", 32'h52, q);
    results();
  end
endmodule
